// ==== iec_pkg.sv ====
// Constants for the interval and event counter block
package iec_pkg;
    // Register addresses
    localparam logic [15:0] IEC_ADDR_PORT3_DIR  = 16'hFF23;
    localparam logic [15:0] IEC_ADDR_RUN_CTRL_B = 16'hFF43;
    localparam logic [15:0] IEC_ADDR_INPUT_SW   = 16'hFF4F;
    localparam logic [15:0] IEC_ADDR_RUN_CTRL_C = 16'hFF5C;
    // Reset values
    localparam logic [7:0]  IEC_RST_PORT3_DIR   = 8'hFF;
    localparam logic [7:0]  IEC_RST_RUN_CTRL    = 8'h00;
    localparam logic [7:0]  IEC_RST_INPUT_SW    = 8'h00;
    // Field masks and positions
    localparam logic [7:0]  IEC_PORT3_FIXED     = 8'hE1;
    localparam logic [7:0]  IEC_RUN_CTRL_MASK   = 8'h80;
    localparam logic [7:0]  IEC_INPUT_SW_MASK   = 8'h3F;
    localparam int          IEC_RUN_EN_BIT      = 7;
    localparam int          IEC_EVENT_PIN_BIT   = 4;
    localparam int          IEC_SER_SEL_HI_BIT  = 5;
    localparam int          IEC_SER_SEL_LO_BIT  = 4;
    localparam int          IEC_SER_RX_EN_BIT   = 3;
    localparam int          IEC_GATE_SEL_BIT    = 2;
    localparam int          IEC_CAPTURE_SEL_BIT = 1;
    localparam int          IEC_IRQ0_SEL_BIT    = 0;
    // Serial pin pair patterns
    localparam logic [1:0]  IEC_SER_PINS_DEFAULT = 2'h0;
    localparam logic [1:0]  IEC_SER_PINS_ALT     = 2'h2;
    // Count clock select codes
    localparam logic [2:0]  IEC_CS_FALL         = 3'h0;
    localparam logic [2:0]  IEC_CS_RISE         = 3'h1;
    localparam logic [2:0]  IEC_CS_DIV_BASE     = 3'h2;
    localparam logic [2:0]  IEC_CS_ALT_TICK     = 3'h7;
    // Prescaler taps: divide by 1, 2, 16, 64, 256, 4096
    localparam int          IEC_DIV_TAPS        = 6;
    localparam int          IEC_PRESCALE_W      = 12;
    localparam int          IEC_DIV_SHIFT [IEC_DIV_TAPS] = '{0, 1, 4, 6, 8, 12};
    // Counter width
    localparam int          IEC_CNT_W           = 8;
endpackage

// ==== iec_prescaler.sv ====
// Free-running prescaler giving one-cycle count enables
`timescale 1ns/100ps
module iec_prescaler
    import iec_pkg::*;
#(
    parameter int W = iec_pkg::IEC_PRESCALE_W
) (
    // Clock and reset
    input  wire logic                          i_sys_clk,
    input  wire logic                          i_rst_n,
    // Enable pulses, one per tap
    output logic [iec_pkg::IEC_DIV_TAPS-1:0]   o_tick
);
    logic [W-1:0] cnt_q;

    // Never restarted by a counter start, so start phase is arbitrary
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    for (genvar g = 0; g < IEC_DIV_TAPS; g++) begin : g_tap
        localparam logic [W:0] MASK_WIDE = (W + 1)'((1 << IEC_DIV_SHIFT[g]) - 1);
        localparam logic [W-1:0] MASK    = MASK_WIDE[W-1:0];
        assign o_tick[g] = &(cnt_q | ~MASK);
    end
endmodule // iec_prescaler

// ==== iec_counter.sv ====
// One 8-bit up-counter with compare-match clear
`timescale 1ns/100ps
module iec_counter
    import iec_pkg::*;
#(
    parameter int W = iec_pkg::IEC_CNT_W
) (
    // Clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    // Control
    input  wire logic         i_run,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_compare_value,
    // Status
    output logic [W-1:0]      o_count,
    output logic              o_match_irq
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic         match_q;
    wire  logic   hit = (count_q == i_compare_value);

    always_comb begin
        count_d = count_q;
        if (!i_run) begin
            count_d = '0;
        end else if (i_tick) begin
            count_d = hit ? '0 : count_q + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= '0;
            match_q <= 1'b0;
        end else begin
            count_q <= count_d;
            match_q <= i_run && i_tick && hit;
        end
    end

    assign o_count     = count_q;
    assign o_match_irq = match_q;

    stop_clear_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n) !i_run |=> o_count == '0)
        else $error("stopped counter not cleared");
    match_clear_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_run && i_tick && hit |=> o_count == '0 && o_match_irq)
        else $error("match did not clear and flag");
    step_one_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_run && i_tick && !hit |=> o_count == $past(o_count) + 1'b1 && !o_match_irq)
        else $error("count did not step by one");
    hold_idle_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_run && !i_tick ##1 i_run |-> $stable(o_count))
        else $error("count moved without a tick");
endmodule // iec_counter

// ==== iec_event_counter.sv ====
// Two 8-bit interval counters, the second also an event counter
`timescale 1ns/100ps
// Summary of operation
// - Run-enable low clears and stops counter; high starts counting selected clock
// - Gate select set passes event pin only while gating timer output high
// - Upper input switch bits pick serial pins: 00 default, 10 alternate
// - Switch bits enable default receive pin, route receive to capture, irq0
// - Input switch resets to 00H, takes bit and byte writes
// - Port3 direction: 0 drives, 1 inputs; resets FFH, bits 7,6,5,0 fixed 1; event pin oe is bit 4 itself, so high for 1
// - On compare match counter clears, keeps counting, raises match request
// - Interval equals compare value plus one count clocks, for 01H-FFH
// - Three low clock-select bits choose each counter's count clock
// - Event counter increments on chosen pin edge, clears and flags on match
// - First match after start may be off by one count clock
// - Upper 16-bit counter drops its first cascade clock after start
// - Event select 000/001 edges of gated pin; 010-111 divide 1..4096
module iec_event_counter
    import iec_pkg::*;
(
    // Clock and reset
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_rst_n,
    // Register access
    input  wire logic [15:0]                     i_addr,
    input  wire logic                            i_wr_en,
    input  wire logic [7:0]                      i_wr_data,
    input  wire logic                            i_bit_wr,
    input  wire logic [2:0]                      i_bit_sel,
    input  wire logic                            i_bit_val,
    input  wire logic                            i_rd_en,
    output logic [7:0]                           o_rd_data,
    // Counter setup
    input  wire logic [2:0]                      i_clock_select,
    input  wire logic [2:0]                      i_event_clock_select,
    input  wire logic [iec_pkg::IEC_CNT_W-1:0]   i_compare_value,
    input  wire logic [iec_pkg::IEC_CNT_W-1:0]   i_event_compare_value,
    input  wire logic                            i_alt_count_tick,
    // Pins
    input  wire logic                            i_event_input_pin,
    input  wire logic                            i_serial_rx_default_pin,
    input  wire logic                            i_serial_rx_alt_pin,
    input  wire logic                            i_capture_input_pin,
    input  wire logic                            i_ext_irq0_pin,
    output logic                                 o_event_pin_oe,
    // Gating timer
    input  wire logic                            i_gating_timer_output,
    // Counter status
    output logic [iec_pkg::IEC_CNT_W-1:0]        o_up_counter,
    output logic [iec_pkg::IEC_CNT_W-1:0]        o_event_counter,
    output logic                                 o_match_irq,
    output logic                                 o_event_match_irq,
    output logic                                 o_cascade_tick,
    // Routing
    output logic [7:0]                           o_port3_direction,
    output logic [1:0]                           o_serial_pin_select,
    output logic                                 o_serial_rx_line,
    output logic                                 o_capture_source,
    output logic                                 o_ext_irq0_source
);
    import iec_pkg::*;

    logic [7:0] port3_dir_q;
    logic [7:0] run_ctrl_b_q;
    logic [7:0] input_sw_q;
    logic [7:0] run_ctrl_c_q;
    logic [7:0] rd_data_q;
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic       gated_prev_q;
    logic       serial_rx_q;
    logic       capture_q;
    logic       irq0_q;

    // Register write decode
    wire logic       any_wr      = i_wr_en || i_bit_wr;
    wire logic       hit_dir     = any_wr && (i_addr == IEC_ADDR_PORT3_DIR);
    wire logic       hit_run_b   = any_wr && (i_addr == IEC_ADDR_RUN_CTRL_B);
    wire logic       hit_sw      = any_wr && (i_addr == IEC_ADDR_INPUT_SW);
    wire logic       hit_run_c   = any_wr && (i_addr == IEC_ADDR_RUN_CTRL_C);
    wire logic [7:0] bit_mask    = 8'h01 << i_bit_sel;

    // Byte write replaces, bit write merges one bit into the current value
    // All inputs passed in, so the assignments re-evaluate on every strobe change
    function automatic logic [7:0] merge(input logic [7:0] cur, input logic bw, input logic bv,
                                         input logic [7:0] mask, input logic [7:0] wd);
        merge = bw ? ((cur & ~mask) | ({8{bv}} & mask)) : wd;
    endfunction

    wire logic [7:0] port3_dir_m  = merge(port3_dir_q, i_bit_wr, i_bit_val, bit_mask, i_wr_data);
    wire logic [7:0] run_ctrl_b_m = merge(run_ctrl_b_q, i_bit_wr, i_bit_val, bit_mask, i_wr_data);
    wire logic [7:0] input_sw_m   = merge(input_sw_q, i_bit_wr, i_bit_val, bit_mask, i_wr_data);
    wire logic [7:0] run_ctrl_c_m = merge(run_ctrl_c_q, i_bit_wr, i_bit_val, bit_mask, i_wr_data);
    wire logic [7:0] port3_dir_d  = port3_dir_m | IEC_PORT3_FIXED;
    wire logic [7:0] run_ctrl_b_d = run_ctrl_b_m & IEC_RUN_CTRL_MASK;
    wire logic [7:0] input_sw_d   = input_sw_m & IEC_INPUT_SW_MASK;
    wire logic [7:0] run_ctrl_c_d = run_ctrl_c_m & IEC_RUN_CTRL_MASK;

    // Read decode; unmapped addresses read zero
    wire logic [7:0] rd_mux =
        (i_addr == IEC_ADDR_PORT3_DIR)  ? port3_dir_q  :
        (i_addr == IEC_ADDR_RUN_CTRL_B) ? run_ctrl_b_q :
        (i_addr == IEC_ADDR_INPUT_SW)   ? input_sw_q   :
        (i_addr == IEC_ADDR_RUN_CTRL_C) ? run_ctrl_c_q : 8'h00;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port3_dir_q  <= IEC_RST_PORT3_DIR;
            run_ctrl_b_q <= IEC_RST_RUN_CTRL;
            input_sw_q   <= IEC_RST_INPUT_SW;
            run_ctrl_c_q <= IEC_RST_RUN_CTRL;
        end else begin
            if (hit_dir) begin
                port3_dir_q <= port3_dir_d;
            end
            if (hit_run_b) begin
                run_ctrl_b_q <= run_ctrl_b_d;
            end
            if (hit_sw) begin
                input_sw_q <= input_sw_d;
            end
            if (hit_run_c) begin
                run_ctrl_c_q <= run_ctrl_c_d;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_data_q <= 8'h00;
        end else if (i_rd_en) begin
            rd_data_q <= rd_mux;
        end
    end

    // Field views
    wire logic run_b     = run_ctrl_b_q[IEC_RUN_EN_BIT];
    wire logic run_c     = run_ctrl_c_q[IEC_RUN_EN_BIT];
    wire logic gate_sel  = input_sw_q[IEC_GATE_SEL_BIT];
    wire logic ser_hi    = input_sw_q[IEC_SER_SEL_HI_BIT];
    wire logic rx_en     = input_sw_q[IEC_SER_RX_EN_BIT];
    wire logic cap_sel   = input_sw_q[IEC_CAPTURE_SEL_BIT];
    wire logic irq0_sel  = input_sw_q[IEC_IRQ0_SEL_BIT];

    // Pin synchronisers: event, rx default, rx alternate, capture, irq0
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
        end else begin
            pin_s1_q <= {i_event_input_pin, i_serial_rx_default_pin, i_serial_rx_alt_pin,
                         i_capture_input_pin, i_ext_irq0_pin};
            pin_s2_q <= pin_s1_q;
        end
    end

    wire logic ev_pin   = pin_s2_q[4];
    wire logic rx_def   = pin_s2_q[3];
    wire logic rx_alt   = pin_s2_q[2];
    wire logic cap_pin  = pin_s2_q[1];
    wire logic irq0_pin = pin_s2_q[0];

    // Gating timer output is same-clock logic, so no synchroniser
    wire logic ev_gated = ev_pin && (!gate_sel || i_gating_timer_output);
    wire logic ev_fall  = gated_prev_q && !ev_gated;
    wire logic ev_rise  = !gated_prev_q && ev_gated;

    // Idle-high receive line when default pin is disabled and alternate pins not selected
    wire logic rx_line_d = ser_hi ? rx_alt : (rx_en ? rx_def : 1'b1);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gated_prev_q <= 1'b0;
            serial_rx_q  <= 1'b1;
            capture_q    <= 1'b0;
            irq0_q       <= 1'b0;
        end else begin
            gated_prev_q <= ev_gated;
            serial_rx_q  <= rx_line_d;
            capture_q    <= cap_sel ? rx_line_d : cap_pin;
            irq0_q       <= irq0_sel ? rx_line_d : irq0_pin;
        end
    end

    // Count clock selection
    logic [IEC_DIV_TAPS-1:0] pre_tick;

    iec_prescaler u_prescaler (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .o_tick    (pre_tick)
    );

    wire logic [2:0] tap_b = 3'(i_clock_select - IEC_CS_DIV_BASE);
    wire logic [2:0] tap_c = 3'(i_event_clock_select - IEC_CS_DIV_BASE);

    // Codes 000 and 001 are prohibited for counter b and give no tick
    wire logic tick_b =
        (i_clock_select == IEC_CS_ALT_TICK) ? i_alt_count_tick :
        (i_clock_select <  IEC_CS_DIV_BASE) ? 1'b0 : pre_tick[tap_b];

    wire logic tick_c =
        (i_event_clock_select == IEC_CS_FALL) ? ev_fall :
        (i_event_clock_select == IEC_CS_RISE) ? ev_rise :
        pre_tick[tap_c];

    // Prescaler free-runs, so the first interval may be up to one tick short
    iec_counter u_counter_b (
        .i_sys_clk       (i_sys_clk),
        .i_rst_n         (i_rst_n),
        .i_run           (run_b),
        .i_tick          (tick_b),
        .i_compare_value (i_compare_value),
        .o_count         (o_up_counter),
        .o_match_irq     (o_match_irq)
    );

    iec_counter u_counter_c (
        .i_sys_clk       (i_sys_clk),
        .i_rst_n         (i_rst_n),
        .i_run           (run_c),
        .i_tick          (tick_c),
        .i_compare_value (i_event_compare_value),
        .o_count         (o_event_counter),
        .o_match_irq     (o_event_match_irq)
    );

    // Upper counter clock; that counter's own start sync drops the first one
    assign o_cascade_tick      = o_event_match_irq;
    assign o_rd_data           = rd_data_q;
    assign o_port3_direction   = port3_dir_q;
    assign o_event_pin_oe      = port3_dir_q[IEC_EVENT_PIN_BIT];
    assign o_serial_pin_select = {ser_hi, input_sw_q[IEC_SER_SEL_LO_BIT]};
    assign o_serial_rx_line    = serial_rx_q;
    assign o_capture_source    = capture_q;
    assign o_ext_irq0_source   = irq0_q;

    gate_block_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        gate_sel && !i_gating_timer_output |-> !ev_gated)
        else $error("gated event input leaked");
    dir_fixed_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (o_port3_direction & IEC_PORT3_FIXED) == IEC_PORT3_FIXED)
        else $error("fixed direction bits cleared");
    switch_write_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        hit_sw && i_wr_en && !i_bit_wr |=> input_sw_q == ($past(i_wr_data) & IEC_INPUT_SW_MASK))
        else $error("input switch byte write lost");
    fall_count_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        run_c && i_event_clock_select == IEC_CS_FALL && ev_fall
            && o_event_counter != i_event_compare_value
        |=> o_event_counter == $past(o_event_counter) + 1'b1)
        else $error("falling edge not counted");
    slow_tap_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_event_clock_select == 3'h7 && tick_c |-> pre_tick[IEC_DIV_TAPS-1])
        else $error("slowest tap not selected");
    serial_alt_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ser_hi |=> o_serial_rx_line == $past(rx_alt))
        else $error("alternate receive pin not routed");
    stop_hold_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !run_b [*2] |-> o_up_counter == '0 && !o_match_irq)
        else $error("stopped counter moved");
endmodule // iec_event_counter

// ==== iec_pulse_src.sv ====
// Pulse source model for the event input pin
`timescale 1ns/100ps
module iec_pulse_src (
    // Clock
    input  wire logic       i_sys_clk,
    // Control
    input  wire logic       i_start,
    input  wire logic [7:0] i_pulses,
    input  wire logic [7:0] i_half,
    input  wire logic       i_idle,
    // Pin side
    output logic            o_pin,
    output logic            o_busy
);
    logic [8:0] edges_q = 9'h000;
    logic [7:0] wait_q  = 8'h00;
    logic       pin_q   = 1'b0;
    // Two edges a pulse; quiescent level held between bursts
    always_ff @(posedge i_sys_clk) begin
        if (i_start) begin
            edges_q <= {i_pulses, 1'b0};
            wait_q  <= i_half;
        end else if (edges_q != 9'h000) begin
            if (wait_q == 8'h00) begin
                pin_q   <= ~pin_q;
                edges_q <= edges_q - 9'h001;
                wait_q  <= i_half;
            end else begin
                wait_q <= wait_q - 8'h01;
            end
        end else begin
            pin_q <= i_idle;
        end
    end
    assign o_pin  = pin_q;
    assign o_busy = (edges_q != 9'h000);
endmodule // iec_pulse_src

// ==== tb_iec_event_counter.sv ====
// Register, routing and counter tests for the counter block
`timescale 1ns/100ps
module tb_iec_event_counter;
    import iec_pkg::*;
    logic        clk, rst_n, wr_en, bit_wr, bit_val, rd_en, alt, ev_pin, gate;
    logic        rxd, rxa, cap, irq0, oe, mirq, emirq, rxl, caps, irq0s;
    logic        ps_start, ps_idle, ps_busy, ctk;
    int          casc_n;
    logic [15:0] addr;
    logic [7:0]  wr_data, rd_data, cmp, ecmp, upc, evc, p3dir, ps_n, rv;
    logic [2:0]  bit_sel, csel, ecsel;
    logic [1:0]  sps;
    int          miscompares, tests_run, ev_hits, cyc_n, p, h;
    int tev[14]  = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1};
    int tsel[14] = '{2, 3, 4, 5, 6, 7, 2, 2, 2, 3, 4, 5, 6, 7};
    int tcmp[14] = '{3, 3, 3, 3, 1, 3, 1, 255, 1, 1, 1, 1, 1, 1};
    int texp[14] = '{4, 8, 64, 256, 512, 12, 2, 256, 2, 4, 32, 128, 512, 8192};
    logic [15:0] ra[5] = '{16'hFF23, 16'hFF43, 16'hFF4F, 16'hFF5C, 16'hFF00};
    logic [7:0]  rx[5] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  ri[3] = '{8'h00, 8'h0B, 8'h23};
    logic [7:0]  ro[3] = '{8'h07, 8'h00, 8'h17};

    iec_event_counter u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wr_en(wr_en), .i_wr_data(wr_data), .i_bit_wr(bit_wr), .i_bit_sel(bit_sel),
        .i_bit_val(bit_val), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_clock_select(csel),
        .i_event_clock_select(ecsel), .i_compare_value(cmp), .i_event_compare_value(ecmp),
        .i_alt_count_tick(alt), .i_event_input_pin(ev_pin), .i_serial_rx_default_pin(rxd),
        .i_serial_rx_alt_pin(rxa), .i_capture_input_pin(cap), .i_ext_irq0_pin(irq0),
        .o_event_pin_oe(oe), .i_gating_timer_output(gate), .o_up_counter(upc),
        .o_event_counter(evc), .o_match_irq(mirq), .o_event_match_irq(emirq),
        .o_cascade_tick(ctk), .o_port3_direction(p3dir), .o_serial_pin_select(sps),
        .o_serial_rx_line(rxl), .o_capture_source(caps), .o_ext_irq0_source(irq0s));
    iec_pulse_src u_src (.i_sys_clk(clk), .i_start(ps_start), .i_pulses(ps_n),
        .i_half(8'h04), .i_idle(ps_idle), .o_pin(ev_pin), .o_busy(ps_busy));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Sampled mid-cycle, away from the launching edge
    always @(negedge clk) if (emirq === 1'b1) ev_hits++;
    // Upper counter model: one cascade clock per lower match
    always @(negedge clk) if (ctk === 1'b1) casc_n++;
    // Alternate count tick every third cycle
    always @(negedge clk) begin
        cyc_n++;
        alt <= (cyc_n % 3 == 0);
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk); addr = a; wr_data = d; wr_en = 1'b1;
        @(negedge clk); wr_en = 1'b0;
    endtask
    task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
        @(negedge clk); addr = a; bit_sel = b; bit_val = v; bit_wr = 1'b1;
        @(negedge clk); bit_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(negedge clk); addr = a; rd_en = 1'b1;
        @(negedge clk); rd_en = 1'b0; rv = rd_data;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        chk8(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic chkn(input string n, input int e, input int g);
        tests_run++;
        if (g != e) begin
            miscompares++;
            $display("[ERR] %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic pulse(input logic [7:0] n);
        int k;
        k = 0;
        ps_n = n; ps_start = 1'b1; cyc(1); ps_start = 1'b0;
        while (ps_busy === 1'b1 && k < 500) begin cyc(1); k++; end
        cyc(8);
    endtask
    // Cycles between two successive match pulses
    task automatic period(input int ev, output int n);
        int k;
        k = 0; n = 0; cyc(1);
        while (((ev == 1) ? emirq : mirq) !== 1'b1 && k < 9000) begin cyc(1); k++; end
        do begin cyc(1); n++; end while (((ev == 1) ? emirq : mirq) !== 1'b1 && n < 9000);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        {rst_n, wr_en, bit_wr, bit_val, rd_en, gate, ps_start, ps_idle} = 8'h00;
        {addr, wr_data, bit_sel, csel, ecsel, cmp, ecmp, ps_n} = '0;
        {rxd, rxa, cap, irq0} = 4'h7;
        cyc(8);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin rd(ra[i]); chk8("reset value", rx[i], rv); end
        chk1("pin oe", 1'b1, oe);
        $display("test reset_values done");
        wr(16'hFF23, 8'h00); rd(16'hFF23); chk8("port3 dir", 8'hE1, rv);
        chk8("port3 dir out", 8'hE1, p3dir);
        chk1("pin oe", 1'b0, oe);
        wr(16'hFF00, 8'h55); bwr(16'hFF23, 3'h4, 1'b1); rd(16'hFF23);
        chk8("port3 dir bit", 8'hF1, rv);
        chk1("pin oe", 1'b1, oe);
        wr(16'hFF4F, 8'hFF); rd(16'hFF4F); chk8("switch", 8'h3F, rv);
        bwr(16'hFF4F, 3'h2, 1'b0); rd(16'hFF4F); chk8("switch bit", 8'h3B, rv);
        wr(16'hFF5C, 8'h7F); rd(16'hFF5C); chk8("run c", 8'h00, rv);
        wr(16'hFF43, 8'hFF); rd(16'hFF43); chk8("run b", 8'h80, rv);
        wr(16'hFF43, 8'h00); wr(16'hFF23, 8'hFF);
        $display("test register_access done");
        rxd = 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(16'hFF4F, ri[i]); cyc(6);
            chk8("routing", ro[i], {3'h0, sps, rxl, caps, irq0s});
        end
        wr(16'hFF4F, 8'h00);
        $display("test routing done");
        for (int i = 0; i < 14; i++) begin
            wr((tev[i] == 1) ? 16'hFF5C : 16'hFF43, 8'h00);
            if (tev[i] == 1) {ecsel, ecmp} = {3'(tsel[i]), 8'(tcmp[i])};
            else {csel, cmp} = {3'(tsel[i]), 8'(tcmp[i])};
            wr((tev[i] == 1) ? 16'hFF5C : 16'hFF43, 8'h80);
            period(tev[i], p);
            chkn("period", texp[i], p);
            wr((tev[i] == 1) ? 16'hFF5C : 16'hFF43, 8'h00); cyc(2);
            chk8("stopped", 8'h00, (tev[i] == 1) ? evc : upc);
        end
        $display("test intervals done");
        for (int s = 0; s < 2; s++) begin
            ecsel = 3'(s); ecmp = 8'h02; ps_idle = (s == 0); cyc(8);
            h = ev_hits;
            wr(16'hFF5C, 8'h80); pulse(8'h05);
            chk8("event count", 8'h02, evc);
            chkn("event matches", h + 1, ev_hits);
            chkn("cascade ticks", h + 1, casc_n);
            wr(16'hFF5C, 8'h00); cyc(2); chk8("event stopped", 8'h00, evc);
        end
        bwr(16'hFF4F, 3'h2, 1'b1); ecsel = 3'h1; ecmp = 8'h05; ps_idle = 1'b0; cyc(8);
        wr(16'hFF5C, 8'h80); pulse(8'h03);
        chk8("gated closed", 8'h00, evc);
        gate = 1'b1; pulse(8'h03);
        chk8("gated open", 8'h03, evc);
        wr(16'hFF5C, 8'h00);
        $display("test event_counting done");
        rst_n = 1'b0; cyc(2); rst_n = 1'b1;
        rd(16'hFF4F); chk8("switch after reset", 8'h00, rv);
        chk8("count after reset", 8'h00, evc);
        $display("test mid_reset done");
        final_report();
    end
    // Whole run needs roughly 20000 cycles
    initial begin
        #4000000;
        miscompares++;
        final_report();
    end
endmodule // tb_iec_event_counter
